// ===== arfq_word_filter.v
// Contract
// - parity off: bit 32 passes unchanged
// - parity on, odd: bit 32 cleared
// - parity on, even: bit 32 set, stored
// - end-of-word strobe pulses after each check, with word_loaded
// - load only on label and sdi match
// - loaded word sets data ready, clears empty
// - empty stays low until last word read
// - opcode 08 returns oldest stored word
// - holds 32 words; full at 32
// - when full, overwrite location 32
// - half full at 16 or more words
// - 256-bit label table, one enables label
// - table written by opcodes 02, 03, 06
// - rejected word changes nothing visible
// - table read back by opcode 0D
// - master reset clears fifo, flags, flag pin
// - master reset keeps configuration bits
// - flag pin shows empty or full by select
`include "arfq_regs.vh"
module arfq_word_filter (
   clk,
   rst_b,
   master_reset_pin,
   rx_word_valid,
   rx_word_ready,
   rx_word,
   parity_check_enable,
   label_filter_enable,
   sdi_match_enable,
   sdi_match_bit_a,
   sdi_match_bit_b,
   flag_pin_select,
   cmd_valid,
   cmd_ready,
   cmd_opcode,
   cmd_label,
   cmd_wdata,
   rsp_valid,
   rsp_data,
   end_of_word_strobe,
   word_loaded,
   data_ready,
   fifo_empty_flag,
   fifo_half_full_flag,
   fifo_full_flag,
   receive_flag_pin,
   fifo_count
);
   input wire clk;
   input wire rst_b;
   input wire master_reset_pin;
   input wire rx_word_valid;
   output wire rx_word_ready;
   input wire [31:0] rx_word;
   input wire parity_check_enable;
   input wire label_filter_enable;
   input wire sdi_match_enable;
   input wire sdi_match_bit_a;
   input wire sdi_match_bit_b;
   input wire flag_pin_select;
   input wire cmd_valid;
   output wire cmd_ready;
   input wire [7:0] cmd_opcode;
   input wire [7:0] cmd_label;
   input wire [255:0] cmd_wdata;
   output reg rsp_valid;
   output reg [255:0] rsp_data;
   output reg end_of_word_strobe;
   output reg word_loaded;
   output reg data_ready;
   output reg fifo_empty_flag;
   output reg fifo_half_full_flag;
   output reg fifo_full_flag;
   output reg receive_flag_pin;
   output reg [5:0] fifo_count;

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function is_table_write;
      input [7:0] op;
      begin
         is_table_write = (op == `ARFQ_OP_LABEL_WR0) || (op == `ARFQ_OP_LABEL_WR1) ||
            (op == `ARFQ_OP_LABEL_WR2);
      end
   endfunction

   // label sits in arinc bits 1..8, held here at word bits 7:0 whatever the host bit order
   function [7:0] label_of;
      input [31:0] w;
      begin
         label_of = w[7:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // staging buffer: decoder words wait here while a read or a table access runs
   localparam ST_IDLE = 2'b00;
   localparam ST_READ = 2'b01;
   localparam ST_RESP = 2'b10;

   reg [1:0] state_q;
   wire stg_valid;
   wire [31:0] stg_word;
   wire stg_pop;
   wire flush;

   assign flush = master_reset_pin;
   assign stg_pop = stg_valid && (state_q == ST_IDLE) && !cmd_valid && !flush;

   arfq_stage #(
      .W(`ARFQ_WORD_W),
      .DEPTH(`ARFQ_STAGE_DEPTH),
      .AW(`ARFQ_STAGE_AW)
   ) u_stage (
      .clk(clk),
      .rst_b(rst_b),
      .flush(flush),
      .in_valid(rx_word_valid),
      .in_ready(rx_word_ready),
      .in_data(rx_word),
      .out_valid(stg_valid),
      .out_ready(stg_pop),
      .out_data(stg_word)
   );

   ////////////////////////////////////////////////////////////////////////
   // label table; no reset so the host image survives master reset
   reg [255:0] label_table_q;
   wire label_hit;
   wire sdi_hit;
   wire accept;
   wire [31:0] fixed_word;

   assign label_hit = label_table_q[label_of(stg_word)];
   assign sdi_hit = (stg_word[`ARFQ_SDI_HI] == sdi_match_bit_a) &&
      (stg_word[`ARFQ_SDI_LO] == sdi_match_bit_b);
   assign accept = (!label_filter_enable || label_hit) &&
      (!sdi_match_enable || sdi_hit);

   // bit 32 becomes an error marker: even overall parity sets it, odd clears it
   assign fixed_word = parity_check_enable ?
      {~^stg_word, stg_word[30:0]} : stg_word;

   // a command counts only on the edge where both sides agree; a held request
   // during a word read must not write the table twice
   wire cmd_take;
   wire cmd_is_wr;
   wire cmd_is_rd;
   assign cmd_take = cmd_valid && cmd_ready;
   assign cmd_is_wr = cmd_take && is_table_write(cmd_opcode);
   assign cmd_is_rd = cmd_take && (cmd_opcode == `ARFQ_OP_READ_WORD);

   always @(posedge clk) begin
      if (cmd_is_wr) begin
         label_table_q <= cmd_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive fifo storage and pointers
   reg [4:0] wp_q;
   reg [4:0] rp_q;
   reg [5:0] cnt_q;
   wire [31:0] ram_rdata;
   wire full_now;
   wire do_load;
   wire do_pop;
   wire [4:0] wr_addr;

   assign full_now = (cnt_q == `ARFQ_FULL);
   assign do_load = stg_pop && accept;
   // a read on an empty fifo pops nothing and answers zero
   assign do_pop = cmd_is_rd && (cnt_q != 6'h00);
   // when full the newest slot (the 32nd) is rewritten, older entries stay put
   assign wr_addr = full_now ? (wp_q - 5'h01) : wp_q;

   arfq_ram #(
      .W(`ARFQ_WORD_W),
      .AW(5)
   ) u_ram (
      .clk(clk),
      .we(do_load),
      .waddr(wr_addr),
      .wdata(fixed_word),
      .raddr(rp_q),
      .rdata(ram_rdata)
   );

   always @(posedge clk) begin
      if (!rst_b || flush) begin
         wp_q <= 5'h00;
         rp_q <= 5'h00;
         cnt_q <= 6'h00;
      end else begin
         if (do_load && !full_now) begin
            wp_q <= wp_q + 5'h01;
         end
         if (do_pop) begin
            rp_q <= rp_q + 5'h01;
         end
         if (do_load && !full_now && !do_pop) begin
            cnt_q <= cnt_q + 6'h01;
         end else if (do_pop && !(do_load && !full_now)) begin
            cnt_q <= cnt_q - 6'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // host command sequencing: read takes two extra cycles (ST_READ, ST_RESP) for the registered ram port
   assign cmd_ready = (state_q == ST_IDLE) && !flush;

   // remembers whether the accepted read found a word to return
   reg cnt_q_at_cmd_q;
   // oldest word, caught from the ram port before the moved pointer replaces it
   reg [31:0] rd_word_q;

   // the ram port shows the popped slot only in the cycle after the pop; one
   // edge later it already follows the advanced read pointer, so hold it here
   always @(posedge clk) begin
      if (!rst_b || flush) begin
         rd_word_q <= 32'h0;
      end else if (state_q == ST_READ) begin
         rd_word_q <= ram_rdata;
      end
   end

   always @(posedge clk) begin
      if (!rst_b || flush) begin
         state_q <= ST_IDLE;
         rsp_valid <= 1'b0;
         rsp_data <= 256'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               rsp_valid <= 1'b0;
               if (cmd_valid && cmd_opcode == `ARFQ_OP_READ_WORD) begin
                  state_q <= ST_READ;
               end else if (cmd_valid && cmd_opcode == `ARFQ_OP_LABEL_RD) begin
                  rsp_valid <= 1'b1;
                  rsp_data <= label_table_q;
               end else if (cmd_valid && is_table_write(cmd_opcode)) begin
                  rsp_valid <= 1'b1;
                  rsp_data <= 256'h0;
               end else if (cmd_valid) begin
                  rsp_valid <= 1'b1;
                  rsp_data <= 256'h0;
               end
            end
            ST_READ: begin
               state_q <= ST_RESP;
            end
            ST_RESP: begin
               rsp_valid <= 1'b1;
               // an empty fifo answers zero rather than stale data
               rsp_data <= {224'h0, (cnt_q_at_cmd_q ? rd_word_q : 32'h0)};
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge clk) begin
      if (!rst_b || flush) begin
         cnt_q_at_cmd_q <= 1'b0;
      end else if (cmd_take) begin
         cnt_q_at_cmd_q <= do_pop;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status flags follow the occupancy count one cycle later
   wire [5:0] cnt_d;
   assign cnt_d = cnt_q;

   always @(posedge clk) begin
      if (!rst_b || flush) begin
         end_of_word_strobe <= 1'b0;
         word_loaded <= 1'b0;
         data_ready <= 1'b0;
         fifo_empty_flag <= 1'b1;
         fifo_half_full_flag <= 1'b0;
         fifo_full_flag <= 1'b0;
         receive_flag_pin <= 1'b0;
         fifo_count <= 6'h00;
      end else begin
         end_of_word_strobe <= stg_pop;
         word_loaded <= do_load;
         fifo_count <= cnt_d;
         data_ready <= (cnt_d != 6'h00);
         fifo_empty_flag <= (cnt_d == 6'h00);
         fifo_half_full_flag <= (cnt_d >= `ARFQ_HALF);
         fifo_full_flag <= (cnt_d == `ARFQ_FULL);
         receive_flag_pin <= flag_pin_select ? (cnt_d == `ARFQ_FULL) :
            (cnt_d == 6'h00);
      end
   end

   // configuration bits are plain inputs held by the host, so reset cannot touch them
endmodule // arfq_word_filter

// ===== arfq_regs.vh
`ifndef ARFQ_REGS_VH
`define ARFQ_REGS_VH
`define ARFQ_WORD_W 32
`define ARFQ_DEPTH 32
`define ARFQ_CNT_W 6
`define ARFQ_HALF 6'h10
`define ARFQ_FULL 6'h20
`define ARFQ_OP_READ_WORD 8'h08
`define ARFQ_OP_LABEL_WR0 8'h02
`define ARFQ_OP_LABEL_WR1 8'h03
`define ARFQ_OP_LABEL_WR2 8'h06
`define ARFQ_OP_LABEL_RD 8'h0D
`define ARFQ_PARITY_BIT 31
`define ARFQ_SDI_LO 8
`define ARFQ_SDI_HI 9
`define ARFQ_STAGE_DEPTH 8
`define ARFQ_STAGE_AW 3
`endif

// ===== arfq_ram.v
`include "arfq_regs.vh"
// receive word store, registered read port
module arfq_ram #(
   parameter W = 32,
   parameter AW = 5
) (
   clk,
   we,
   waddr,
   wdata,
   raddr,
   rdata
);
   input wire clk;
   input wire we;
   input wire [AW-1:0] waddr;
   input wire [W-1:0] wdata;
   input wire [AW-1:0] raddr;
   output reg [W-1:0] rdata;
   reg [W-1:0] mem [0:(1<<AW)-1];
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // arfq_ram

// ===== arfq_stage.v
`include "arfq_regs.vh"
// small staging fifo between the word decoder and the acceptance logic
module arfq_stage #(
   parameter W = 32,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   clk,
   rst_b,
   flush,
   in_valid,
   in_ready,
   in_data,
   out_valid,
   out_ready,
   out_data
);
   input wire clk;
   input wire rst_b;
   input wire flush;
   input wire in_valid;
   output wire in_ready;
   input wire [W-1:0] in_data;
   output wire out_valid;
   input wire out_ready;
   output wire [W-1:0] out_data;
   reg [W-1:0] buf_q [0:DEPTH-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;
   localparam [AW:0] CNT_FULL = DEPTH;
   assign in_ready = (cnt_q != CNT_FULL);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = buf_q[rp_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always @(posedge clk) begin
      if (push) begin
         buf_q[wp_q] <= in_data;
      end
   end
   always @(posedge clk) begin
      if (!rst_b || flush) begin
         wp_q <= {AW{1'b0}};
         rp_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // arfq_stage

// ===== arfq_word_filter_assertions.sv
module arfq_word_filter_chk (
   input wire clk,
   input wire rst_b,
   input wire master_reset_pin,
   input wire cmd_valid,
   input wire cmd_ready,
   input wire [7:0] cmd_opcode,
   input wire rsp_valid,
   input wire end_of_word_strobe,
   input wire word_loaded,
   input wire data_ready,
   input wire fifo_empty_flag,
   input wire fifo_half_full_flag,
   input wire fifo_full_flag,
   input wire [5:0] fifo_count
);
   timeunit 1ns;
   timeprecision 1ps;
   wire acc = cmd_valid && cmd_ready;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // flags and the count are registered in the same cycle, yet each flag check waits for two equal samples
   chk_count_cap: assert property (fifo_count <= 6'h20)
      else $error("count above depth");
   chk_empty_low: assert property ((fifo_count != 6'h00) [*2] |-> !fifo_empty_flag)
      else $error("empty flag high with words stored");
   chk_empty_high: assert property ((fifo_count == 6'h00) [*2] |-> fifo_empty_flag)
      else $error("empty flag low with no words");
   chk_half_set: assert property ((fifo_count >= 6'h10) [*2] |-> fifo_half_full_flag)
      else $error("half flag low at sixteen or more");
   chk_half_clr: assert property ((fifo_count < 6'h10) [*2] |-> !fifo_half_full_flag)
      else $error("half flag high below sixteen");
   chk_full_set: assert property ((fifo_count == 6'h20) [*2] |-> fifo_full_flag)
      else $error("full flag low at depth");
   chk_grow_one: assert property (fifo_count > $past(fifo_count) |->
      fifo_count == $past(fifo_count) + 6'h01 && (word_loaded || $past(word_loaded)))
      else $error("count grew without a loaded word");
   chk_reject_still: assert property (end_of_word_strobe && !word_loaded |->
      $stable(fifo_count) && $stable(data_ready) ##1 $stable(fifo_count))
      else $error("rejected word changed state");
   chk_ready_set: assert property (word_loaded |-> ##[0:1] data_ready)
      else $error("data ready not set");
   chk_read_lat: assert property (acc && cmd_opcode == 8'h08 |-> ##3 rsp_valid)
      else $error("word read answer late");
   chk_table_lat: assert property (acc && cmd_opcode == 8'h0D |=> rsp_valid)
      else $error("table read answer late");
   chk_mreset_clear: assert property (master_reset_pin |-> !cmd_ready ##1 fifo_count == 6'h00)
      else $error("master reset did not clear");
   cover property (word_loaded);
   cover property (end_of_word_strobe && !word_loaded);
   cover property (fifo_full_flag && word_loaded);
endmodule // arfq_word_filter_chk

bind arfq_word_filter arfq_word_filter_chk u_arfq_word_filter_chk (.clk, .rst_b,
   .master_reset_pin, .cmd_valid, .cmd_ready, .cmd_opcode, .rsp_valid, .end_of_word_strobe,
   .word_loaded, .data_ready, .fifo_empty_flag, .fifo_half_full_flag, .fifo_full_flag,
   .fifo_count);

// ===== arfq_host_model.sv
module arfq_host_model (
   input wire clk,
   input wire cmd_ready,
   input wire rsp_valid,
   input wire [255:0] rsp_data,
   output logic cmd_valid,
   output logic [7:0] cmd_opcode,
   output logic [7:0] cmd_label,
   output logic [255:0] cmd_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   int gap = 0;
   logic [255:0] rsp;
   initial begin
      cmd_valid = 1'b0;
      cmd_opcode = 8'h00;
      cmd_label = 8'h00;
      cmd_wdata = '0;
   end
   // one transaction at a time; a slow host idles gap cycles first
   task automatic req(input logic [7:0] op, input logic [255:0] wd);
      int i;
      repeat (gap) @(posedge clk);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_opcode <= op;
      cmd_wdata <= wd;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (cmd_ready === 1'b1) break;
      end
      cmd_valid <= 1'b0;
      // released lines carry junk, never the old request
      cmd_opcode <= ~op;
      cmd_wdata <= ~wd;
      for (i = 0; i < 8 && rsp_valid !== 1'b1; i++) @(posedge clk);
      rsp = rsp_data;
   endtask
endmodule // arfq_host_model

// ===== arfq_word_filter_tb.sv
module arfq_word_filter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_b = 1'b0, master_reset_pin = 1'b0, rx_word_valid = 1'b0;
   logic parity_check_enable = 1'b0, label_filter_enable = 1'b0, sdi_match_enable = 1'b0;
   logic sdi_match_bit_a = 1'b1, sdi_match_bit_b = 1'b0, flag_pin_select = 1'b0;
   logic [31:0] rx_word = 32'h0;
   logic [7:0] cmd_opcode, cmd_label;
   logic [255:0] cmd_wdata, rsp_data, tbl;
   logic rx_word_ready, cmd_valid, cmd_ready, rsp_valid, end_of_word_strobe, word_loaded;
   logic data_ready, fifo_empty_flag, fifo_half_full_flag, fifo_full_flag, receive_flag_pin;
   logic [5:0] fifo_count;
   logic [31:0] q[$];
   logic [7:0] ops[3] = '{8'h02, 8'h03, 8'h06};
   int n_fail = 0, n_tests = 0, i;
   always #5 clk = ~clk;
   arfq_word_filter u_arfq_word_filter (.clk, .rst_b, .master_reset_pin, .rx_word_valid,
      .rx_word_ready, .rx_word, .parity_check_enable, .label_filter_enable, .sdi_match_enable,
      .sdi_match_bit_a, .sdi_match_bit_b, .flag_pin_select, .cmd_valid, .cmd_ready, .cmd_opcode,
      .cmd_label, .cmd_wdata, .rsp_valid, .rsp_data, .end_of_word_strobe, .word_loaded,
      .data_ready, .fifo_empty_flag, .fifo_half_full_flag, .fifo_full_flag, .receive_flag_pin,
      .fifo_count);
   arfq_host_model u_arfq_host_model (.clk, .cmd_ready, .rsp_valid, .rsp_data, .cmd_valid,
      .cmd_opcode, .cmd_label, .cmd_wdata);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [255:0] seen, input logic [255:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic flags;
      check(fifo_count, 256'(q.size()));
      check(fifo_empty_flag, q.size() == 0);
      check(fifo_half_full_flag, q.size() >= 16);
      check(fifo_full_flag, q.size() == 32);
   endtask
   // expected word and acceptance worked out before the word goes in
   task automatic send(input logic [31:0] w);
      logic [31:0] m;
      @(posedge clk);
      m = w;
      if (parity_check_enable) m[31] = ~^w;
      if ((!label_filter_enable || tbl[w[7:0]]) &&
          (!sdi_match_enable || w[9:8] == {sdi_match_bit_a, sdi_match_bit_b})) begin
         if (q.size() == 32) q[31] = m;
         else q.push_back(m);
      end
      rx_word_valid <= 1'b1;
      rx_word <= w;
      do @(posedge clk); while (rx_word_ready !== 1'b1);
      rx_word_valid <= 1'b0;
      rx_word <= ~w;
      repeat (4) @(posedge clk);
      flags;
   endtask
   task automatic rd;
      logic [31:0] e;
      e = (q.size() != 0) ? q.pop_front() : 32'h0;
      u_arfq_host_model.req(8'h08, 256'h0);
      check(u_arfq_host_model.rsp, {224'h0, e});
      repeat (2) @(posedge clk);
      flags;
   endtask
   task automatic print_verdict;
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      print_verdict;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      flags;
      for (i = 0; i < 3; i++) begin
         tbl = {32{8'h96}} ^ (256'(i) << 5);
         u_arfq_host_model.req(ops[i], tbl);
         u_arfq_host_model.gap = i;
         u_arfq_host_model.req(8'h0D, 256'h0);
         check(u_arfq_host_model.rsp, tbl);
      end
      rd;
      for (i = 0; i < 4; i++) begin
         parity_check_enable <= i[1];
         send(32'h8000_0F00 | i);
      end
      check(data_ready, 1'b1);
      while (q.size() != 0) rd;
      label_filter_enable <= 1'b1; // table already loaded
      for (i = 0; i < 8; i++) begin
         sdi_match_enable <= i[2];
         send({22'h0, i[1:0], 8'h11 + 8'(i)});
      end
      while (q.size() != 0) rd;
      label_filter_enable <= 1'b0;
      sdi_match_enable <= 1'b0;
      flag_pin_select <= 1'b1;
      for (i = 0; i < 33; i++) send(32'h0101_0101 * i);
      check(receive_flag_pin, 1'b1);
      flag_pin_select <= 1'b0;
      while (q.size() != 0) rd;
      check(receive_flag_pin, 1'b1);
      parity_check_enable <= 1'b1;
      for (i = 0; i < 3; i++) send(32'h0000_0700 + i);
      master_reset_pin <= 1'b1;
      repeat (3) @(posedge clk);
      master_reset_pin <= 1'b0;
      q.delete();
      repeat (3) @(posedge clk);
      flags;
      send(32'h0000_0001);
      rd;
      print_verdict;
   end
endmodule // arfq_word_filter_tb
